// [core/cur_path_pkg.sv]
// constants and encodings of the current-channel waveform path
// Functional notes
// - modulator strobe and one bitstream bit every master clock divided by four
// - decimation filter averages the one-bit stream into 20-bit proportional words
// - code equals 1.512 times input over reference times 262144, same on both channels
// - waveform words are signed 20-bit, fastest one per 128 master clocks
// - converter output clamps at 40000h and C0000h, never wraps
// - nominal full-scale input swings the code between D7AE1h and 2851Fh
// - channel-one word multiplied by one plus signed 12-bit gain over 4096
// - gain 7FFh raises output about half, 800h lowers it about half
// - mode bits 14:13 equal to 1,0 route channel-one samples to waveform output
// - power path keeps receiving scaled words while waveform sampling runs
// - mode bits 12:11 pick 27.9k, 14k, 7k or 3.5k samples per second
// - active-low interrupt goes low whenever a new waveform sample is available
// - samples leave in 8-bit units, most significant byte first
// - each 20-bit sample is sign-extended and right-justified into three bytes
package cur_path_pkg;
  // --------------------------------------------------------------
  // widths
  // --------------------------------------------------------------
  localparam int SAMPLE_W = 20;
  localparam int WORD_W = 24;
  localparam int BYTE_W = 8;
  localparam int GAIN_W = 12;
  localparam int GAIN_FRAC = 12;
  // --------------------------------------------------------------
  // timing and decimation
  // --------------------------------------------------------------
  localparam int MOD_DIV = 4;
  localparam logic [1:0] MOD_DIV_LAST = 2'h3;
  localparam int BASE_DECIM = 128;
  localparam int BASE_BITS = BASE_DECIM / MOD_DIV;
  localparam int FULL_SHIFT = 18;
  localparam int BASE_SHIFT = FULL_SHIFT - $clog2(BASE_BITS);
  // --------------------------------------------------------------
  // code limits and mode encodings
  // --------------------------------------------------------------
  localparam logic [SAMPLE_W-1:0] CLAMP_POS = 20'h40000;
  localparam logic [SAMPLE_W-1:0] CLAMP_NEG = 20'hC0000;
  localparam logic [1:0] WAVE_SEL_CH1 = 2'h2;
  localparam logic [1:0] WAVE_SEL_BIT_HI = 2'h1;
  localparam logic [1:0] RATE_FASTEST = 2'h0;
  typedef enum logic [1:0] {
    SER_IDLE = 2'b00,
    SER_BYTE_HI = 2'b01,
    SER_BYTE_MID = 2'b10,
    SER_BYTE_LO = 2'b11
  } ser_state_t;
endpackage

// [core/sample_buffer.sv]
// small flip-flop buffer with valid/ready on both sides
`timescale 1ns/1ps
module sample_buffer #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [IW-1:0] LAST_IDX = IW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("sample_buffer needs DEPTH of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [IW-1:0] wr_idx;
  logic [IW-1:0] rd_idx;
  logic [CW-1:0] count;

  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;
  wire [IW-1:0] next_wr_idx = (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
  wire [IW-1:0] next_rd_idx = (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;

  assign in_ready = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_idx];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (do_wr) wr_idx <= next_wr_idx;
      if (do_rd) rd_idx <= next_rd_idx;
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (do_wr) mem[wr_idx] <= in_data;
  end
endmodule // sample_buffer

// [core/current_channel_waveform_path.sv]
// digital side of the current channel: decimation, gain, waveform output
`timescale 1ns/1ps
module current_channel_waveform_path
  import cur_path_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic mod_bit,
  input wire logic [GAIN_W-1:0] power_gain_word,
  input wire logic [1:0] wave_mode_sel,
  input wire logic [1:0] wave_rate_sel,
  input wire logic waveform_sample_enable,
  input wire logic status_read_done,
  input wire logic byte_ready,
  output logic mod_clk_out,
  output logic [SAMPLE_W-1:0] scaled_word,
  output logic scaled_valid,
  output logic [BYTE_W-1:0] byte_data,
  output logic byte_valid,
  output logic irq_n,
  output logic sample_lost
);
  if (BUF_DEPTH < 2) begin : g_bad
    $error("BUF_DEPTH must be at least 2");
  end

  // --------------------------------------------------------------
  // modulator clock
  // --------------------------------------------------------------
  logic [1:0] div_cnt;
  wire mod_tick = (div_cnt == MOD_DIV_LAST);
  wire [1:0] next_div_cnt = div_cnt + 2'h1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 2'h0;
      mod_clk_out <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      mod_clk_out <= next_div_cnt[1];
    end
  end

  // --------------------------------------------------------------
  // decimation filter
  // --------------------------------------------------------------
  logic [7:0] bit_cnt;
  logic [8:0] ones;
  logic [1:0] win_rate;
  logic signed [SAMPLE_W-1:0] raw_q;
  logic raw_valid;

  wire [9:0] win_len = 10'(BASE_BITS) << win_rate;
  wire [7:0] win_last = 8'(win_len - 10'h1);
  wire win_end = mod_tick && (bit_cnt == win_last);
  wire [8:0] next_ones = ones + {8'h00, mod_bit};
  // bipolar average: ones minus zeros over the window
  wire signed [10:0] diff = $signed({1'b0, next_ones, 1'b0}) - $signed({1'b0, win_len});
  wire [3:0] code_shift = 4'(BASE_SHIFT) - {2'h0, win_rate};
  // full density maps to 2^18, giving the 262144 scale
  wire signed [SAMPLE_W-1:0] diff_wide = {{(SAMPLE_W-11){diff[10]}}, diff};
  wire signed [SAMPLE_W-1:0] raw_code = diff_wide <<< code_shift;
  wire signed [SAMPLE_W-1:0] pos_lim = CLAMP_POS;
  wire signed [SAMPLE_W-1:0] neg_lim = CLAMP_NEG;
  wire signed [SAMPLE_W-1:0] raw_clamped =
    (raw_code > pos_lim) ? pos_lim : (raw_code < neg_lim) ? neg_lim : raw_code;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 8'h00;
      ones <= 9'h000;
      win_rate <= RATE_FASTEST;
      raw_q <= '0;
      raw_valid <= 1'b0;
    end else begin
      raw_valid <= win_end;
      if (win_end) begin
        bit_cnt <= 8'h00;
        ones <= 9'h000;
        win_rate <= wave_rate_sel;
        raw_q <= raw_clamped;
      end else if (mod_tick) begin
        bit_cnt <= bit_cnt + 8'h01;
        ones <= next_ones;
      end
    end
  end

  // --------------------------------------------------------------
  // gain stage
  // --------------------------------------------------------------
  wire signed [GAIN_W-1:0] gain_s = power_gain_word;
  wire signed [SAMPLE_W+GAIN_W-1:0] prod = raw_q * gain_s;
  wire signed [SAMPLE_W+GAIN_W-1:0] prod_frac = prod >>> GAIN_FRAC;
  wire signed [SAMPLE_W+1:0] gain_sum =
    {{2{raw_q[SAMPLE_W-1]}}, raw_q} + 22'(prod_frac);
  wire signed [SAMPLE_W+1:0] pos_lim_w = {2'b00, CLAMP_POS};
  wire signed [SAMPLE_W+1:0] neg_lim_w = {2'b11, CLAMP_NEG};
  wire signed [SAMPLE_W-1:0] gain_clamped =
    (gain_sum > pos_lim_w) ? pos_lim :
    (gain_sum < neg_lim_w) ? neg_lim : SAMPLE_W'(gain_sum);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scaled_word <= '0;
      scaled_valid <= 1'b0;
    end else begin
      scaled_valid <= raw_valid;
      if (raw_valid) scaled_word <= gain_clamped;
    end
  end

  // --------------------------------------------------------------
  // waveform routing and buffer
  // --------------------------------------------------------------
  wire wave_on = (wave_mode_sel == WAVE_SEL_CH1);
  wire push_valid = scaled_valid && wave_on;
  wire [WORD_W-1:0] push_word =
    {{(WORD_W-SAMPLE_W){scaled_word[SAMPLE_W-1]}}, scaled_word};
  wire push_ready;
  wire pop_valid;
  wire [WORD_W-1:0] pop_word;
  ser_state_t ser_state;
  wire pop_ready = (ser_state == SER_IDLE);
  wire pushed = push_valid && push_ready;

  sample_buffer #(
    .WIDTH(WORD_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(push_valid),
    .in_data(push_word),
    .in_ready(push_ready),
    .out_valid(pop_valid),
    .out_data(pop_word),
    .out_ready(pop_ready)
  );

  // --------------------------------------------------------------
  // sample announcement
  // --------------------------------------------------------------
  logic pend;
  wire next_pend = pushed || (pend && !status_read_done);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend <= 1'b0;
      irq_n <= 1'b1;
      sample_lost <= 1'b0;
    end else begin
      pend <= next_pend;
      irq_n <= !(next_pend && waveform_sample_enable);
      sample_lost <= push_valid && !push_ready;
    end
  end

  // --------------------------------------------------------------
  // byte serializer
  // --------------------------------------------------------------
  logic [WORD_W-1:0] ser_word;
  wire byte_taken = byte_valid && byte_ready;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_state <= SER_IDLE;
      ser_word <= '0;
      byte_data <= 8'h00;
      byte_valid <= 1'b0;
    end else begin
      case (ser_state)
        SER_IDLE: begin
          if (pop_valid) begin
            ser_word <= pop_word;
            byte_data <= pop_word[23:16];
            byte_valid <= 1'b1;
            ser_state <= SER_BYTE_HI;
          end
        end
        SER_BYTE_HI: begin
          if (byte_taken) begin
            byte_data <= ser_word[15:8];
            ser_state <= SER_BYTE_MID;
          end
        end
        SER_BYTE_MID: begin
          if (byte_taken) begin
            byte_data <= ser_word[7:0];
            ser_state <= SER_BYTE_LO;
          end
        end
        SER_BYTE_LO: begin
          if (byte_taken) begin
            byte_valid <= 1'b0;
            ser_state <= SER_IDLE;
          end
        end
        default: begin
          byte_valid <= 1'b0;
          ser_state <= SER_IDLE;
        end
      endcase
    end
  end
endmodule // current_channel_waveform_path

// [dv/cur_path_host.sv]
// far-side host model: reads waveform bytes, acknowledges interrupts
`timescale 1ns/1ps
module cur_path_host (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic irq_n,
  input wire logic hold,
  output logic byte_ready,
  output logic status_read_done
);
  initial begin
    byte_ready = 1'b0;
    status_read_done = 1'b0;
  end
  // takes bytes at a random pace, stalls while hold is set
  always @(posedge core_clk) begin
    #2;
    byte_ready = rst_n && !hold && ($urandom % 3 != 0);
    status_read_done = rst_n && !irq_n && !status_read_done && ($urandom % 5 == 0);
  end
endmodule // cur_path_host

// [dv/current_channel_waveform_path_assertions.sv]
// port checker for the current-channel waveform path
`timescale 1ns/1ps
module cur_path_checker
  import cur_path_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [1:0] wave_mode_sel,
  input wire logic waveform_sample_enable,
  input wire logic status_read_done,
  input wire logic byte_ready,
  input wire logic mod_clk_out,
  input wire logic [SAMPLE_W-1:0] scaled_word,
  input wire logic scaled_valid,
  input wire logic [BYTE_W-1:0] byte_data,
  input wire logic byte_valid,
  input wire logic irq_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_mod_rate; $rose(mod_clk_out) |-> ##4 $rose(mod_clk_out); endproperty
  a_mod_rate: assert property (p_mod_rate) else $error("modulator clock period");
  property p_clamp;
    scaled_valid |-> $signed(scaled_word) <= $signed(CLAMP_POS)
      && $signed(scaled_word) >= $signed(CLAMP_NEG);
  endproperty
  a_clamp: assert property (p_clamp) else $error("word beyond clamp");
  property p_word_gap; scaled_valid |=> (!scaled_valid) [*8]; endproperty
  a_word_gap: assert property (p_word_gap) else $error("words too close");
  // falls one edge after the push, or when enable comes up on an already pending flag
  property p_irq_cause;
    $fell(irq_n) |-> $past(waveform_sample_enable) && (!$past(waveform_sample_enable, 2) ||
      ($past(scaled_valid) && $past(wave_mode_sel) == WAVE_SEL_CH1));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without sample");
  property p_irq_mask; (!waveform_sample_enable) [*2] |-> irq_n; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt low");
  property p_irq_release;
    status_read_done && !$past(scaled_valid) && !scaled_valid |=> irq_n;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt not released");
  property p_byte_hold; byte_valid && !byte_ready |=> byte_valid && $stable(byte_data); endproperty
  a_byte_hold: assert property (p_byte_hold) else $error("byte dropped in stall");
  property p_byte_first;
    $rose(byte_valid) && $past(scaled_valid, 2) |->
      byte_data == {{4{scaled_word[19]}}, scaled_word[19:16]};
  endproperty
  a_byte_first: assert property (p_byte_first) else $error("first byte wrong");
  c_wave: cover property (scaled_valid && wave_mode_sel == WAVE_SEL_CH1);
  c_stall: cover property (byte_valid && !byte_ready);
  c_release: cover property (status_read_done && !irq_n);
endmodule // cur_path_checker
bind current_channel_waveform_path cur_path_checker u_chk (.core_clk, .rst_n, .wave_mode_sel,
  .waveform_sample_enable, .status_read_done, .byte_ready, .mod_clk_out, .scaled_word,
  .scaled_valid, .byte_data, .byte_valid, .irq_n);

// [dv/current_channel_waveform_path_test.sv]
// self-checking bench for the current-channel waveform path
`timescale 1ns/1ps
module current_channel_waveform_path_test;
  import cur_path_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic mod_bit = 1'b0;
  logic [GAIN_W-1:0] power_gain_word = '0;
  logic [1:0] wave_mode_sel = 2'h0;
  logic [1:0] wave_rate_sel = 2'h0;
  logic waveform_sample_enable = 1'b1;
  logic hold = 1'b0;
  logic status_read_done, byte_ready, mod_clk_out, scaled_valid, byte_valid, irq_n, sample_lost;
  logic [SAMPLE_W-1:0] scaled_word;
  logic [BYTE_W-1:0] byte_data;
  logic [3:0] pat = 4'h0;
  logic armed = 1'b0;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;
  int lost = 0;
  logic [SAMPLE_W-1:0] sq[$];
  logic [BYTE_W-1:0] bq[$];
  current_channel_waveform_path DUT (.core_clk, .rst_n, .mod_bit, .power_gain_word,
    .wave_mode_sel, .wave_rate_sel, .waveform_sample_enable, .status_read_done, .byte_ready,
    .mod_clk_out, .scaled_word, .scaled_valid, .byte_data, .byte_valid, .irq_n, .sample_lost);
  cur_path_host u_host (.core_clk, .rst_n, .irq_n, .hold, .byte_ready, .status_read_done);
  always #25 core_clk = ~core_clk;
  // --------------------------------------------------------------
  // stimulus helpers
  // --------------------------------------------------------------
  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [SAMPLE_W-1:0] expw(input int ones4, input logic [GAIN_W-1:0] g);
    longint code;
    code = longint'(2 * ones4 - 4) <<< 16;
    code = code + ((code * longint'($signed(g))) >>> 12);
    if (code > 262144) code = 262144;
    if (code < -262144) code = -262144;
    return code[SAMPLE_W-1:0];
  endfunction
  task automatic next_word(output int gap);
    gap = 0;
    do begin
      @(posedge core_clk);
      gap++;
    end while (scaled_valid !== 1'b1 && gap < 3000);
    #2;
  endtask
  task automatic run_row(input int ones4, input logic [11:0] g, input logic [1:0] r,
                         input logic en, input int n, input int kept, input logic h);
    int gap;
    logic [23:0] x;
    logic [SAMPLE_W-1:0] w;
    pat = 4'(4'hF >> (4 - ones4));
    power_gain_word = g;
    wave_rate_sel = r;
    waveform_sample_enable = en;
    hold = h;
    repeat (3) next_word(gap);
    w = expw(ones4, g);
    x = {{4{w[SAMPLE_W-1]}}, w};
    for (int i = 0; i < n; i++) sq.push_back(w);
    for (int i = 0; i < 3 * kept; i++) bq.push_back(x[23 - 8 * (i % 3) -: 8]);
    wave_mode_sel = WAVE_SEL_CH1;
    armed = 1'b1;
    for (int i = 0; i < n; i++) begin
      next_word(gap);
      check(24'(gap), 24'(128 << r));
    end
    wave_mode_sel = 2'h0;
    armed = 1'b0;
    hold = 1'b0;
    for (int i = 0; i < 400 && bq.size() > 0; i++) @(posedge core_clk);
    #2;
  endtask
  // --------------------------------------------------------------
  // monitor and sequence
  // --------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (sample_lost === 1'b1) lost++;
    if (armed && scaled_valid === 1'b1 && sq.size() > 0)
      check(scaled_word, sq.pop_front());
    if (byte_valid === 1'b1 && byte_ready === 1'b1)
      check(byte_data, bq.size() ? bq.pop_front() : 'x);
    #2;
    mod_bit = pat[cyc[3:2]];
  end
  always @(posedge core_clk) if (cyc == 60000) begin
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(32'hDF7B9A48));
    repeat (20) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    run_row(4, 12'h000, 2'h0, 1'b1, 3, 3, 1'b0);
    run_row(0, 12'h7FF, 2'h1, 1'b1, 3, 3, 1'b0);
    run_row(4, 12'h800, 2'h2, 1'b0, 3, 3, 1'b0);
    check(24'(irq_n), 24'h000001);
    run_row(4, 12'h7FF, 2'h0, 1'b1, 2, 2, 1'b0);
    run_row(2, 12'h7FF, 2'h3, 1'b1, 2, 2, 1'b0);
    for (int k = 0; k < 3; k++) run_row(3, 12'($urandom), 2'($urandom), 1'b1, 3, 3, 1'b0);
    lost = 0;
    run_row(4, 12'h000, 2'h0, 1'b1, 4, 3, 1'b1);
    check(24'(lost), 24'h000001);
    check(24'(bq.size()), 24'h000000);
    close_out();
  end
endmodule // current_channel_waveform_path_test
